// [hdl/dac_serial_pkg.sv]
package dac_serial_pkg;
   localparam int FRAME_BITS = 16;
   localparam int CODE_BITS = 12;
   localparam int MODE_BITS = 2;
   localparam int COUNT_BITS = 5;
   localparam logic [COUNT_BITS-1:0] LAST_BIT = 5'h10;
   localparam logic [COUNT_BITS-1:0] COUNT_ZERO = 5'h00;
   localparam logic [COUNT_BITS-1:0] COUNT_ONE = 5'h01;
   localparam int CODE_LSB = 0;
   localparam int MODE_LSB = 12;
   localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
   localparam logic [MODE_BITS-1:0] MODE_RESET = 2'h0;
   localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
   localparam logic [2:0] PIPE_ONES = 3'h7;
   localparam logic [2:0] PIPE_ZEROS = 3'h0;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_shift = 2'b01,
      st_done = 2'b11
   } frame_state_t;

   typedef struct packed {
      logic [MODE_BITS-1:0] mode;
      logic [CODE_BITS-1:0] code;
   } dac_word_t;
endpackage : dac_serial_pkg

// [hdl/dac_serial_write_port.sv]
// Summary of operation
// - a sixteen bit shift register takes one data bit per serial clock cycle of a frame.
// - data is sampled on each falling serial clock edge, where the host holds it valid.
// - a frame begins when frame sync goes low and shifting is enabled only while it is low.
// - on the sixteenth falling edge the word loads the converter code and the mode.
// - frame sync rising before the sixteenth edge aborts, clears the shift register, changes nothing.
// - the word, first bit first, is two ignored bits, a two bit mode, then a twelve bit code.
// - only a fresh falling edge of frame sync starts the next frame.
// - reset clears the converter code to zero until a complete frame arrives.
module dac_serial_write_port
   import dac_serial_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic sync_n,
   input wire logic sclk,
   input wire logic sdin,
   output dac_serial_pkg::dac_word_t dac_word,
   output logic word_loaded
);
   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic falling(input logic prev, input logic level);
      falling = prev & ~level;
   endfunction : falling

   // the count runs from zero, so the sixteenth bit sits one below the frame length
   function automatic logic [COUNT_BITS-1:0] final_index();
      final_index = LAST_BIT - COUNT_ONE;
   endfunction : final_index

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   // three stages; second and third must agree before a change counts
   logic [2:0] sync_pipe;
   logic [2:0] sclk_pipe;
   logic [2:0] din_pipe;
   logic sync_level;
   logic sclk_level;
   logic din_level;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_pipe <= PIPE_ONES;
         sclk_pipe <= PIPE_ZEROS;
         din_pipe <= PIPE_ZEROS;
      end else begin
         sync_pipe <= {sync_pipe[1:0], sync_n};
         sclk_pipe <= {sclk_pipe[1:0], sclk};
         din_pipe <= {din_pipe[1:0], sdin};
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_level <= 1'b1;
         sclk_level <= 1'b0;
         din_level <= 1'b0;
      end else begin
         if (sync_pipe[1] == sync_pipe[2]) begin
            sync_level <= sync_pipe[2];
         end
         if (sclk_pipe[1] == sclk_pipe[2]) begin
            sclk_level <= sclk_pipe[2];
         end
         if (din_pipe[1] == din_pipe[2]) begin
            din_level <= din_pipe[2];
         end
      end
   end

   // ************************************************************
   // edge detection
   // ************************************************************
   logic sync_prev;
   logic sclk_prev;
   logic sync_fall;
   logic sync_rise;
   logic sclk_fall;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_prev <= 1'b1;
         sclk_prev <= 1'b0;
      end else begin
         sync_prev <= sync_level;
         sclk_prev <= sclk_level;
      end
   end

   assign sync_fall = falling(sync_prev, sync_level);
   assign sync_rise = ~sync_prev & sync_level;
   // data is filtered like the clock but changes well before it, so its level is settled here
   assign sclk_fall = falling(sclk_prev, sclk_level);

   // ************************************************************
   // frame control
   // ************************************************************
   frame_state_t state;
   logic [FRAME_BITS-1:0] shift;
   logic [COUNT_BITS-1:0] count;
   logic [FRAME_BITS-1:0] next_shift;
   logic execute;

   assign next_shift = {shift[FRAME_BITS-2:0], din_level};
   assign execute = (state == st_shift) && sclk_fall && !sync_level
                    && (count == final_index());

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= st_idle;
      end else begin
         unique case (state)
            st_idle: begin
               if (sync_fall) begin
                  state <= st_shift;
               end
            end
            st_shift: begin
               if (sync_level) begin
                  state <= st_idle;
               end else if (execute) begin
                  state <= st_done;
               end
            end
            st_done: begin
               // a new frame needs sync high first, so sit here until it rises
               if (sync_rise) begin
                  state <= st_idle;
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift <= SHIFT_RESET;
         count <= COUNT_ZERO;
      end else if (state != st_shift || sync_level) begin
         shift <= SHIFT_RESET;
         count <= COUNT_ZERO;
      end else if (sclk_fall) begin
         shift <= next_shift;
         // a finished frame parks the count at zero so it never reads past the last index
         if (execute) begin
            count <= COUNT_ZERO;
         end else begin
            count <= count + COUNT_ONE;
         end
      end
   end

   // ************************************************************
   // converter register
   // ************************************************************
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dac_word.code <= CODE_RESET;
         dac_word.mode <= MODE_RESET;
         word_loaded <= 1'b0;
      end else begin
         word_loaded <= execute;
         if (execute) begin
            dac_word.code <= next_shift[CODE_LSB +: CODE_BITS];
            dac_word.mode <= next_shift[MODE_LSB +: MODE_BITS];
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   a_abort_no_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == st_shift && sync_level) |=> $stable(dac_word) && count == COUNT_ZERO)
      else $error("abort changed the converter word");

   a_load_takes_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
      execute |=> word_loaded && dac_word.code == $past(next_shift[CODE_BITS-1:0]))
      else $error("converter code not loaded from shift register");

   a_mode_field: assert property (@(posedge ref_clk) disable iff (sys_rst)
      execute |=> dac_word.mode == $past(next_shift[MODE_LSB +: MODE_BITS]))
      else $error("mode field misplaced");

   a_done_ignores_clk: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == st_done && !sync_rise) |=> state == st_done && !word_loaded)
      else $error("edges acted on after frame end");

   a_count_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
      count <= final_index())
      else $error("shift count beyond frame");

   a_shift_on_fall: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == st_shift && !sync_level && !sclk_fall) |=> $stable(count))
      else $error("shift without falling clock");

   a_start_on_fall: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == st_idle && !sync_fall) |=> state == st_idle)
      else $error("frame started without sync falling");

   a_word_held: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !execute |=> $stable(dac_word))
      else $error("converter word changed without a frame");

   a_abort_clears_shift: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == st_shift && sync_level) |=> shift == SHIFT_RESET)
      else $error("abort left bits in the shift register");

   a_loaded_one_cycle: assert property (@(posedge ref_clk) disable iff (sys_rst)
      word_loaded |=> !word_loaded)
      else $error("load pulse longer than one cycle");

   a_idle_count_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      state != st_shift |-> count == COUNT_ZERO)
      else $error("bit count not cleared outside a frame");

   a_rise_ends_done: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == st_done && sync_rise) |=> state == st_idle)
      else $error("sync rise did not rearm the port");

   a_done_after_last: assert property (@(posedge ref_clk) disable iff (sys_rst)
      execute |=> state == st_done)
      else $error("port still shifting after the last bit");
endmodule : dac_serial_write_port

// [tb/host_serial_model.sv]
module host_serial_model (
   input wire logic ref_clk,
   output logic sync_n,
   output logic sclk,
   output logic sdin
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // host frame driver
   // ****************
   initial begin
      sync_n = 1'b1;
      sclk = 1'b1;
      sdin = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : wait_clk
   // five cycles per phase: the pin filters need four, so slack covers jitter
   task automatic frame(input logic [15:0] w, input int n, input int extra);
      sync_n <= 1'b0;
      wait_clk(5);
      for (int i = 0; i < n + extra; i++) begin
         sdin <= (i < n) ? w[15-i] : ~sdin;
         wait_clk(5);
         sclk <= 1'b0;
         wait_clk(5);
         sclk <= 1'b1;
      end
      sync_n <= 1'b1;
      sdin <= ~sdin;
      wait_clk(12);
   endtask : frame
endmodule : host_serial_model

// [tb/dac_serial_write_port_bench.sv]
module dac_serial_write_port_bench import dac_serial_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(n, e, g) samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end
   // ****************
   // bench
   // ****************
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sync_n, sclk, sdin, word_loaded;
   dac_word_t dac_word;
   dac_word_t exp_word = '0;
   int error_cnt = 0;
   int samples_checked = 0;
   int loads = 0;
   int exp_loads = 0;
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (word_loaded === 1'b1) loads++;
   host_serial_model i_host_serial_model (.ref_clk(ref_clk), .sync_n(sync_n), .sclk(sclk),
      .sdin(sdin));
   dac_serial_write_port i_dac_serial_write_port (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .sync_n(sync_n), .sclk(sclk), .sdin(sdin), .dac_word(dac_word), .word_loaded(word_loaded));
   task finish_test;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   task check_state;
      `CHK("dac_word", exp_word, dac_word)
      `CHK("loads", exp_loads, loads)
   endtask : check_state
   task test_reset;
      `CHK("word_loaded", 1'b0, word_loaded)
      check_state();
   endtask : test_reset
   // top two bits set so an ignored bit leaking into mode shows up
   task test_modes;
      for (int m = 0; m < 4; m++) begin
         i_host_serial_model.frame({2'b11, 2'(m), 10'h2c3, ~2'(m)}, 16, 0);
         exp_word = {2'(m), 10'h2c3, ~2'(m)};
         exp_loads++;
         check_state();
      end
   endtask : test_modes
   task test_abort;
      i_host_serial_model.frame(16'h1234, 15, 0);
      check_state();
      i_host_serial_model.frame(16'h0fff, 16, 0);
      exp_word = 14'h0fff;
      exp_loads++;
      check_state();
   endtask : test_abort
   task test_extra;
      i_host_serial_model.frame(16'h6a5e, 16, 4);
      exp_word = 14'h2a5e;
      exp_loads++;
      check_state();
      i_host_serial_model.frame(16'h1001, 16, 0);
      exp_word = 14'h1001;
      exp_loads++;
      check_state();
   endtask : test_extra
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      test_reset();
      test_modes();
      test_abort();
      test_extra();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      finish_test();
   end
endmodule : dac_serial_write_port_bench
